// ### irq_status_regs.vh
// How it works
// R1 - Load current done flag sets on result ready, holds until host writes one.
// R2 - Bit 6 mirrors any pending bit in the monitor event register.
// R3 - Bit 5 mirrors any pending bit in the boost event register.
// R4 - Bit 4 mirrors any pending bit in the buck event register.
// R5 - Bit 3 latches on every sync clock valid/invalid transition.
// R6 - Thermal cutoff latches bit 2 and disables all enabled converters.
// R7 - While thermal cutoff latch set, no converter may be enabled.
// R8 - Clearing thermal cutoff re-enables converters and clears warning status.
// R9 - Bit 1 latches thermal warning; live warning shown separately.
// R10 - Bit 0 latches overvoltage; live overvoltage shown separately.
// R11 - Second register bit 0 latches on analog supply undervoltage or software reset.
// R12 - Reset event disables converters, defaults registers, restarts, keeps flag set.
// R13 - Host writes one to clear a flag; only bits written one clear.
// R14 - Sub-register event bits latch and clear on write one.
// R15 - Software reset bit resets registers, reloads settings, self-clears.
// R16 - Flags read zero after reset; writing zero leaves them unchanged.
`ifndef IRQ_STATUS_REGS_VH
`define IRQ_STATUS_REGS_VH
`define RESET_CTRL_OFFSET   8'h1f
`define TOP_PRIMARY_OFFSET  8'h20
`define TOP_SECONDARY_OFFSET 8'h21
`define BUCK_EVENT_OFFSET   8'h22
`define BOOST_EVENT_OFFSET  8'h23
`define MONITOR_EVENT_OFFSET 8'h24
`define TOP_STATUS_OFFSET   8'h25
`define FLAG_RESET_VALUE    8'h00
`define BIT_LOAD_DONE       7
`define BIT_MONITOR_SUM     6
`define BIT_BOOST_SUM       5
`define BIT_BUCK_SUM        4
`define BIT_SYNC_CLK        3
`define BIT_THERMAL_CUTOFF  2
`define BIT_THERMAL_WARNING 1
`define BIT_OVERVOLTAGE     0
`define BIT_RESET_EVENT     0
`define BIT_SOFTWARE_RESET  0
`define BUCK_EVENT_MASK     8'h77
`define BOOST_EVENT_MASK    8'h07
`define MONITOR_EVENT_MASK  8'h15
`endif

// ### w1c_event_reg.v
`include "irq_status_regs.vh"
// Latched event bits, set wins over write-one clear
module w1c_event_reg #(
    parameter WIDTH = 8,
    parameter [WIDTH-1:0] MASK = {WIDTH{1'b1}}
) (
    // Clock and reset
    input  wire             clk,
    input  wire             rst_n,
    // Events and clear
    input  wire [WIDTH-1:0] setBits,
    input  wire [WIDTH-1:0] clearBits,
    // Stored flags
    output reg  [WIDTH-1:0] flags
);
    wire [WIDTH-1:0] next_flags = ((flags & ~clearBits) | setBits) & MASK;

    // R13 R14 R16 write one clears
    always @(posedge clk) begin
        if (!rst_n) begin
            flags <= {WIDTH{1'b0}};
        end else begin
            flags <= next_flags;
        end
    end
endmodule // w1c_event_reg

// ### top_level_irq_status.v
`include "irq_status_regs.vh"
module top_level_irq_status (
    // Clock and reset
    input  wire       clk,
    input  wire       rst_n,
    // Register port
    input  wire [7:0] regAddr,
    input  wire       regWrite,
    input  wire       regRead,
    input  wire [7:0] regWdata,
    output reg  [7:0] regRdata,
    // Event sources
    input  wire       loadCurrentReady,
    input  wire       syncClockValid,
    input  wire       thermalCutoffLive,
    input  wire       thermalWarningLive,
    input  wire       overvoltageLive,
    input  wire       analogSupplyLow,
    input  wire [7:0] buckEvents,
    input  wire [7:0] boostEvents,
    input  wire [7:0] monitorEvents,
    // Converter control
    input  wire       converterEnableRequest,
    output reg        converterEnable,
    output reg        deviceRestart
);
    reg        loadDoneFlag;
    reg        syncChangeFlag;
    reg        cutoffFlag;
    reg        warnFlag;
    reg        ovpFlag;
    reg  [7:0] next_regRdata;
    reg        resetEvent;
    reg        syncValidPrev;
    reg        warnPrev;
    reg        ovpPrev;
    reg        cutoffPrev;
    reg        warnStatusCleared;
    wire [7:0] buckFlags;
    wire [7:0] boostFlags;
    wire [7:0] monitorFlags;

    function wrHit;
        input [7:0] addr;
        begin
            wrHit = regWrite && (regAddr == addr);
        end
    endfunction

    wire [7:0] primaryClr   = wrHit(`TOP_PRIMARY_OFFSET) ? regWdata : 8'h00;
    wire       resetEventClr = wrHit(`TOP_SECONDARY_OFFSET) && regWdata[`BIT_RESET_EVENT];
    // R15 software reset self-clearing
    wire       swReset = wrHit(`RESET_CTRL_OFFSET) && regWdata[`BIT_SOFTWARE_RESET];
    // R11 reset event cause
    wire       resetCause = swReset || analogSupplyLow;
    wire       softRst_n = rst_n && !resetCause;
    wire       cutoffClr = primaryClr[`BIT_THERMAL_CUTOFF];

    // Sub-register write-one clears
    wire [7:0] buckClr      = wrHit(`BUCK_EVENT_OFFSET) ? regWdata : 8'h00;
    wire [7:0] boostClr     = wrHit(`BOOST_EVENT_OFFSET) ? regWdata : 8'h00;
    wire [7:0] monitorClr   = wrHit(`MONITOR_EVENT_OFFSET) ? regWdata : 8'h00;

    // Single-cycle event strobes
    wire       syncChange   = syncClockValid != syncValidPrev;
    wire       cutoffRise   = thermalCutoffLive && !cutoffPrev;
    wire       warnRise     = thermalWarningLive && !warnPrev;
    wire       ovpRise      = overvoltageLive && !ovpPrev;
    // R6 R7 converter block
    wire       converterBlocked = cutoffFlag || cutoffRise;

    // Set wins over a same-cycle clear
    function latchNext;
        input setNow;
        input held;
        input clearNow;
        begin
            latchNext = setNow || (held && !clearNow);
        end
    endfunction

    // R14 sub-register latches
    w1c_event_reg #(.WIDTH(8), .MASK(`BUCK_EVENT_MASK)) buckReg (
        .clk       (clk),
        .rst_n     (softRst_n),
        .setBits   (buckEvents),
        .clearBits (buckClr),
        .flags     (buckFlags)
    );

    w1c_event_reg #(.WIDTH(8), .MASK(`BOOST_EVENT_MASK)) boostReg (
        .clk       (clk),
        .rst_n     (softRst_n),
        .setBits   (boostEvents),
        .clearBits (boostClr),
        .flags     (boostFlags)
    );

    w1c_event_reg #(.WIDTH(8), .MASK(`MONITOR_EVENT_MASK)) monitorReg (
        .clk       (clk),
        .rst_n     (softRst_n),
        .setBits   (monitorEvents),
        .clearBits (monitorClr),
        .flags     (monitorFlags)
    );

    // Edge detectors for the live inputs
    always @(posedge clk) begin
        if (!softRst_n) begin
            // Sync starts at the pin level, no false change after reset; the other three start at zero
            syncValidPrev <= syncClockValid;
            warnPrev      <= 1'b0;
            ovpPrev       <= 1'b0;
            cutoffPrev    <= 1'b0;
        end else begin
            syncValidPrev <= syncClockValid;
            warnPrev      <= thermalWarningLive;
            ovpPrev       <= overvoltageLive;
            cutoffPrev    <= thermalCutoffLive;
        end
    end

    // R1 R13 R16 load done latch
    always @(posedge clk) begin
        if (!softRst_n) begin
            loadDoneFlag <= 1'b0;
        end else begin
            loadDoneFlag <= latchNext(loadCurrentReady, loadDoneFlag, primaryClr[`BIT_LOAD_DONE]);
        end
    end

    // R5 sync validity change
    always @(posedge clk) begin
        if (!softRst_n) begin
            syncChangeFlag <= 1'b0;
        end else begin
            syncChangeFlag <= latchNext(syncChange, syncChangeFlag, primaryClr[`BIT_SYNC_CLK]);
        end
    end

    // R6 thermal cutoff latch
    always @(posedge clk) begin
        if (!softRst_n) begin
            cutoffFlag <= 1'b0;
        end else begin
            cutoffFlag <= latchNext(cutoffRise, cutoffFlag, cutoffClr);
        end
    end

    // R9 warning latch
    always @(posedge clk) begin
        if (!softRst_n) begin
            warnFlag <= 1'b0;
        end else begin
            warnFlag <= latchNext(warnRise, warnFlag, primaryClr[`BIT_THERMAL_WARNING]);
        end
    end

    // R10 overvoltage latch
    always @(posedge clk) begin
        if (!softRst_n) begin
            ovpFlag <= 1'b0;
        end else begin
            ovpFlag <= latchNext(ovpRise, ovpFlag, primaryClr[`BIT_OVERVOLTAGE]);
        end
    end

    // R8 warning status cleared with cutoff
    always @(posedge clk) begin
        if (!softRst_n) begin
            warnStatusCleared <= 1'b0;
        end else if (cutoffClr && cutoffFlag) begin
            warnStatusCleared <= 1'b1;
        end else if (!thermalWarningLive) begin
            warnStatusCleared <= 1'b0;
        end
    end

    // R11 R12 reset event survives register reset
    always @(posedge clk) begin
        if (!rst_n) begin
            resetEvent <= 1'b0;
        end else begin
            resetEvent <= resetCause || (resetEvent && !resetEventClr);
        end
    end

    // R6 R7 R8 R12 converter gating
    always @(posedge clk) begin
        if (!softRst_n) begin
            converterEnable <= 1'b0;
            deviceRestart <= rst_n;
        end else begin
            converterEnable <= converterEnableRequest && !converterBlocked;
            deviceRestart <= 1'b0;
        end
    end

    // R2 R3 R4 summary bits
    wire [7:0] primaryView = {loadDoneFlag, |monitorFlags, |boostFlags, |buckFlags,
                              syncChangeFlag, cutoffFlag, warnFlag, ovpFlag};
    wire [7:0] topStatus = {5'h00, thermalCutoffLive,
                            thermalWarningLive && !warnStatusCleared, overvoltageLive};

    // R16 unmapped addresses read zero
    always @* begin
        case (regAddr)
            `TOP_PRIMARY_OFFSET:   next_regRdata = primaryView;
            `TOP_SECONDARY_OFFSET: next_regRdata = {7'h00, resetEvent};
            `BUCK_EVENT_OFFSET:    next_regRdata = buckFlags;
            `BOOST_EVENT_OFFSET:   next_regRdata = boostFlags;
            `MONITOR_EVENT_OFFSET: next_regRdata = monitorFlags;
            `TOP_STATUS_OFFSET:    next_regRdata = topStatus;
            default:               next_regRdata = 8'h00;
        endcase
    end

    // Read data held until the next read
    always @(posedge clk) begin
        if (!rst_n) begin
            regRdata <= 8'h00;
        end else if (regRead) begin
            regRdata <= next_regRdata;
        end
    end
endmodule // top_level_irq_status

// ### top_level_irq_status_chk.sv
module top_level_irq_status_chk (
    // Clock and reset
    input wire logic       clk,
    input wire logic       rst_n,
    // Register port
    input wire logic [7:0] regAddr,
    input wire logic       regWrite,
    input wire logic       regRead,
    input wire logic [7:0] regWdata,
    input wire logic [7:0] regRdata,
    // Sources and control
    input wire logic       thermalCutoffLive,
    input wire logic       analogSupplyLow,
    input wire logic       converterEnableRequest,
    input wire logic       converterEnable,
    input wire logic       deviceRestart
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    unmapped_read_a: assert property (regRead && (regAddr > 8'h25 || regAddr < 8'h1f) |=> regRdata == 8'h00)
        else $error("unmapped read not zero");
    cutoff_drop_a: assert property ($rose(thermalCutoffLive) |-> ##[1:2] !converterEnable)
        else $error("converter kept on at cutoff");
    cutoff_hold_a: assert property ($rose(thermalCutoffLive) ##1 !(regWrite && regAddr == 8'h20 && regWdata[2]) |=> !converterEnable)
        else $error("converter on during cutoff");
    no_request_a: assert property (!converterEnableRequest |=> !converterEnable)
        else $error("converter on without request");
    undervolt_off_a: assert property (analogSupplyLow |=> !converterEnable)
        else $error("converter on in undervoltage");
    soft_restart_a: assert property (regWrite && regAddr == 8'h1f && regWdata[0] |-> ##[1:3] deviceRestart)
        else $error("no restart after soft reset");
    restart_pulse_a: assert property (deviceRestart && !analogSupplyLow && !(regWrite && regAddr == 8'h1f && regWdata[0]) |=> !deviceRestart)
        else $error("restart not a single pulse");
    reset_selfclr_a: assert property (regRead && regAddr == 8'h1f |=> !regRdata[0])
        else $error("soft reset bit not cleared");
endmodule // top_level_irq_status_chk

bind top_level_irq_status top_level_irq_status_chk i_top_level_irq_status_chk (.clk(clk), .rst_n(rst_n),
    .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata),
    .thermalCutoffLive(thermalCutoffLive), .analogSupplyLow(analogSupplyLow),
    .converterEnableRequest(converterEnableRequest), .converterEnable(converterEnable),
    .deviceRestart(deviceRestart));

// ### host_model.sv
module host_model (
    // Clock
    input  wire logic       clk,
    // Register port
    output logic      [7:0] regAddr,
    output logic            regWrite,
    output logic            regRead,
    output logic      [7:0] regWdata,
    input  wire logic [7:0] regRdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {regAddr, regWrite, regRead, regWdata} = 18'h00000;
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        {regAddr, regWdata, regWrite} = {a, d, 1'b1};
        @(negedge clk);
        regWrite = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        {regAddr, regRead} = {a, 1'b1};
        @(negedge clk);
        regRead = 1'b0;
        d = regRdata;
    endtask
endmodule // host_model

// ### top_level_irq_status_tb_top.sv
module top_level_irq_status_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk = 1'b0, rst_n = 1'b0, regWrite, regRead, converterEnable, deviceRestart;
    logic [7:0] regAddr, regWdata, regRdata, rdv;
    logic       loadCurrentReady = 1'b0, syncClockValid = 1'b0, thermalCutoffLive = 1'b0;
    logic       thermalWarningLive = 1'b0, overvoltageLive = 1'b0, analogSupplyLow = 1'b0;
    logic       converterEnableRequest = 1'b0;
    logic [7:0] buckEvents = 8'h00, boostEvents = 8'h00, monitorEvents = 8'h00;
    int         numErrors = 0, testsRun = 0;
    always #4 clk = ~clk;
    top_level_irq_status i_top_level_irq_status (.clk, .rst_n, .regAddr, .regWrite, .regRead, .regWdata,
        .regRdata, .loadCurrentReady, .syncClockValid, .thermalCutoffLive, .thermalWarningLive,
        .overvoltageLive, .analogSupplyLow, .buckEvents, .boostEvents, .monitorEvents,
        .converterEnableRequest, .converterEnable, .deviceRestart);
    host_model i_host_model (.clk, .regAddr, .regWrite, .regRead, .regWdata, .regRdata);
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        testsRun++;
        if (seen !== exp) begin
            numErrors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        i_host_model.rd(a, rdv);
        chk(rdv, exp);
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic endSim;
        $display("errors=%0d checks=%0d", numErrors, testsRun);
        if (numErrors == 0 && testsRun > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic testLoadDone;
        rchk(8'h20, 8'h00);
        rchk(8'h30, 8'h00);
        loadCurrentReady = 1'b1;
        tick(1);
        loadCurrentReady = 1'b0;
        i_host_model.wr(8'h20, 8'h00);
        rchk(8'h20, 8'h80);
        i_host_model.wr(8'h20, 8'h80);
        rchk(8'h20, 8'h00);
    endtask
    task automatic testEvents;
        {syncClockValid, thermalWarningLive, overvoltageLive} = 3'h7;
        tick(3);
        rchk(8'h20, 8'h0b);
        rchk(8'h25, 8'h03);
        i_host_model.wr(8'h20, 8'h02);
        rchk(8'h20, 8'h09);
        {syncClockValid, thermalWarningLive, overvoltageLive} = 3'h0;
        i_host_model.wr(8'h20, 8'h09);
        rchk(8'h25, 8'h00);
        rchk(8'h20, 8'h00);
    endtask
    task automatic testSummary;
        for (int i = 0; i < 3; i++) begin
            {buckEvents, boostEvents, monitorEvents} = 24'h010000 >> (8 * i);
            tick(1);
            {buckEvents, boostEvents, monitorEvents} = 24'h000000;
            rchk(8'h22 + i[7:0], 8'h01);
            rchk(8'h20, 8'h10 << i);
            i_host_model.wr(8'h22 + i[7:0], 8'h01);
            rchk(8'h20, 8'h00);
        end
    endtask
    task automatic testMasks;
        {buckEvents, boostEvents, monitorEvents} = 24'hffffff;
        tick(1);
        {buckEvents, boostEvents, monitorEvents} = 24'h000000;
        rchk(8'h22, 8'h77);
        rchk(8'h23, 8'h07);
        rchk(8'h24, 8'h15);
        rchk(8'h20, 8'h70);
        i_host_model.wr(8'h22, 8'h00);
        rchk(8'h22, 8'h77);
        i_host_model.wr(8'h24, 8'h04);
        rchk(8'h24, 8'h11);
        i_host_model.wr(8'h22, 8'h77);
        i_host_model.wr(8'h23, 8'h07);
        i_host_model.wr(8'h24, 8'h11);
        rchk(8'h20, 8'h00);
    endtask
    task automatic testThermal;
        converterEnableRequest = 1'b1;
        tick(3);
        chk({7'h00, converterEnable}, 8'h01);
        {thermalCutoffLive, thermalWarningLive} = 2'h3;
        tick(2);
        chk({7'h00, converterEnable}, 8'h00);
        rchk(8'h20, 8'h06);
        rchk(8'h25, 8'h06);
        thermalCutoffLive = 1'b0;
        tick(3);
        chk({7'h00, converterEnable}, 8'h00);
        i_host_model.wr(8'h20, 8'h04);
        tick(2);
        chk({7'h00, converterEnable}, 8'h01);
        rchk(8'h25, 8'h00);
        rchk(8'h20, 8'h02);
        thermalWarningLive = 1'b0;
        i_host_model.wr(8'h20, 8'h02);
    endtask
    task automatic testReset;
        loadCurrentReady = 1'b1;
        syncClockValid = 1'b1;
        tick(1);
        loadCurrentReady = 1'b0;
        i_host_model.wr(8'h1f, 8'h01);
        chk({7'h00, deviceRestart}, 8'h01);
        tick(4);
        rchk(8'h1f, 8'h00);
        rchk(8'h20, 8'h00);
        rchk(8'h21, 8'h01);
        i_host_model.wr(8'h21, 8'h01);
        rchk(8'h21, 8'h00);
        analogSupplyLow = 1'b1;
        tick(2);
        chk({7'h00, converterEnable}, 8'h00);
        analogSupplyLow = 1'b0;
        tick(4);
        rchk(8'h21, 8'h01);
    endtask
    initial begin
        tick(20);
        rst_n = 1'b1;
        testLoadDone;
        testEvents;
        testSummary;
        testMasks;
        testThermal;
        testReset;
        endSim;
    end
    initial begin
        repeat (2000) @(posedge clk);
        numErrors++;
        endSim;
    end
endmodule // top_level_irq_status_tb_top
